// *** rtl/slc_top.sv ***
// What this block does
// - Enable bit starts driver; clear stops immediately
// - Disabled: all panel pins return to port
// - Waveform bit picks default or low-power
// - Waveform change applies at next frame that sets the flag
// - Control A bits 5,2,1 read zero
// - Flag set at frame start with latch
// - Interrupt when flag, enable, global enable
// - Flag cleared by vector or writing one
// - Low-power waveform: flag every second frame
// - Blank from next frame that sets the flag, pins grounded
// - Clock select: system or async clock
// - Async source: oscillator or external input
// - Half-bias bit picks one-half or one-third
// - Duty field picks duty and commons
// - Unused commons become port pins
// - Port mask sets driven segment count
// - Unmasked segments stay port pins
// - Small variant: mask top bit reads zero
// - Tap field picks divider 16..4096
// - Divider field further divides the tap
// - Divide by field value plus one
// - Blank and waveform latched before frame
// - Frame is 6 or 8 prescaled periods
`timescale 1ns/1ps
`default_nettype none

module slc_top
  import slc_pkg::*;
#(
  parameter int SEG_COUNT = 40
)
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [7:0]           addr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [7:0]           rdata_o,
  input  wire logic                 ext_clk_en_i,
  input  wire logic                 tosc_clk_i,
  input  wire logic                 ext_clk_i,
  input  wire logic                 global_irq_en_i,
  input  wire logic                 irq_ack_i,
  output logic                      frame_irq_o,
  output logic                      frame_start_o,
  output logic                      panel_tick_o,
  output logic      [2:0]           frame_phase_o,
  output logic                      low_power_active_o,
  output logic                      blank_gnd_o,
  output logic                      half_bias_o,
  output logic      [1:0]           duty_o,
  output logic      [3:0]           com_lcd_o,
  output logic      [SEG_COUNT-1:0] seg_lcd_o
);

  localparam logic [3:0] MASK_KEEP = (SEG_COUNT > 25) ? 4'hF : 4'h7;

  logic       panel_driver_on;
  logic       low_power_waveform_sel;
  logic       frame_start_flag;
  logic       frame_irq_enable;
  logic       blank_request;
  logic       async_clock_sel;
  logic       half_bias_sel;
  logic [1:0] duty_sel;
  logic [3:0] segment_pin_mask;
  logic [2:0] prescale_tap_sel;
  logic [2:0] clock_divide_sel;

  slc_state_t state;
  logic       prescaled_panel_clock;
  logic [2:0] phase;
  logic [2:0] phase_last;
  logic       frame_begin;
  logic       second_half;
  logic       latch_now;
  logic       lp_active;
  logic       blank_active;
  logic [5:0] seg_last;
  logic       wr_a;
  logic       wr_b;
  logic       wr_f;
  logic       frame_cut;

  assign wr_a = wr_i && (addr_i == SLC_PANEL_CONTROL_A_OFS);
  assign wr_b = wr_i && (addr_i == SLC_PANEL_CONTROL_B_OFS);
  assign wr_f = wr_i && (addr_i == SLC_FRAME_RATE_OFS);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // reset to zero
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      panel_driver_on        <= SLC_CTRL_A_RESET[SLC_A_DRIVER_ON];
      low_power_waveform_sel <= SLC_CTRL_A_RESET[SLC_A_LP_WAVE];
      frame_irq_enable       <= SLC_CTRL_A_RESET[SLC_A_IRQ_EN];
      blank_request          <= SLC_CTRL_A_RESET[SLC_A_BLANK];
    end
    else if (wr_a)
    begin
      panel_driver_on        <= wdata_i[SLC_A_DRIVER_ON];
      low_power_waveform_sel <= wdata_i[SLC_A_LP_WAVE];
      frame_irq_enable       <= wdata_i[SLC_A_IRQ_EN];
      blank_request          <= wdata_i[SLC_A_BLANK];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      async_clock_sel  <= SLC_CTRL_B_RESET[SLC_B_ASYNC_SEL];
      half_bias_sel    <= SLC_CTRL_B_RESET[SLC_B_HALF_BIAS];
      duty_sel         <= SLC_CTRL_B_RESET[SLC_B_DUTY_LO +: 2];
      segment_pin_mask <= SLC_CTRL_B_RESET[SLC_B_MASK_LO +: 4];
    end
    else if (wr_b)
    begin
      async_clock_sel  <= wdata_i[SLC_B_ASYNC_SEL];
      half_bias_sel    <= wdata_i[SLC_B_HALF_BIAS];
      duty_sel         <= wdata_i[SLC_B_DUTY_LO +: 2];
      segment_pin_mask <= wdata_i[SLC_B_MASK_LO +: 4] & MASK_KEEP;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prescale_tap_sel <= SLC_FRR_RESET[SLC_F_TAP_LO +: 3];
      clock_divide_sel <= SLC_FRR_RESET[SLC_F_DIV_LO +: 3];
    end
    else if (wr_f)
    begin
      prescale_tap_sel <= wdata_i[SLC_F_TAP_LO +: 3];
      clock_divide_sel <= wdata_i[SLC_F_DIV_LO +: 3];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // reserved bits read zero
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 8'h00;
    else if (rd_i && addr_i == SLC_PANEL_CONTROL_A_OFS)
      rdata_o <= {panel_driver_on, low_power_waveform_sel, 1'b0, frame_start_flag,
                  frame_irq_enable, 2'b00, blank_request};
    else if (rd_i && addr_i == SLC_PANEL_CONTROL_B_OFS)
      rdata_o <= {async_clock_sel, half_bias_sel, duty_sel, segment_pin_mask};
    else if (rd_i && addr_i == SLC_FRAME_RATE_OFS)
      rdata_o <= {1'b0, prescale_tap_sel, 1'b0, clock_divide_sel};
    else
      rdata_o <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Prescaled panel clock
  // ----------------------------------------------------------------
  // source, tap and divide
  slc_clk_div u_clk_div (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .run_i        (panel_driver_on),
    .async_sel_i  (async_clock_sel),
    .ext_clk_en_i (ext_clk_en_i),
    .tosc_clk_i   (tosc_clk_i),
    .ext_clk_i    (ext_clk_i),
    .tap_sel_i    (prescale_tap_sel),
    .div_sel_i    (clock_divide_sel),
    .tick_o       (prescaled_panel_clock)
  );

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // six or eight periods
  assign phase_last  = (duty_sel == SLC_DUTY_THIRD) ? SLC_K_THIRD_LAST : SLC_K_OTHER_LAST;
  assign frame_begin = (state == SLC_RUN) && panel_driver_on && prescaled_panel_clock
                       && (phase >= phase_last);

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= SLC_IDLE;
    else
    begin
      case (state)
        SLC_IDLE: if (panel_driver_on) state <= SLC_RUN;
        SLC_RUN:  if (!panel_driver_on) state <= SLC_IDLE;
        default:  state <= SLC_IDLE;
      endcase
    end
  end

  // First tick after enable opens a frame
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      phase <= SLC_K_OTHER_LAST;
    else if (state != SLC_RUN || !panel_driver_on)
      phase <= SLC_K_OTHER_LAST;
    else if (frame_begin)
      phase <= 3'h0;
    else if (prescaled_panel_clock)
      phase <= phase + 3'h1;
  end

  // frames cut by a duty write go untimed
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      frame_cut <= 1'b1;
    else if (wr_b || state != SLC_RUN || frame_begin)
      frame_cut <= wr_b || (state != SLC_RUN);
  end

  // pairs of frames in low-power mode
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      second_half <= 1'b0;
    else if (state != SLC_RUN)
      second_half <= 1'b0;
    else if (frame_begin)
      second_half <= latch_now && low_power_waveform_sel;
  end

  assign latch_now = frame_begin && !(lp_active && second_half);

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lp_active    <= 1'b0;
      blank_active <= 1'b0;
    end
    else if (state != SLC_RUN)
    begin
      lp_active    <= 1'b0;
      blank_active <= 1'b0;
    end
    else if (latch_now)
    begin
      lp_active    <= low_power_waveform_sel;
      blank_active <= blank_request;
    end
  end

  // ----------------------------------------------------------------
  // Start-of-frame flag and interrupt
  // ----------------------------------------------------------------
  // set wins over clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      frame_start_flag <= 1'b0;
    else if (latch_now)
      frame_start_flag <= 1'b1;
    else if (irq_ack_i || (wr_a && wdata_i[SLC_A_FLAG]))
      frame_start_flag <= 1'b0;
  end

  assign frame_irq_o = frame_start_flag && frame_irq_enable && global_irq_en_i;

  // ----------------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------------
  // last driven segment
  always_comb
  begin
    if (segment_pin_mask == 4'h6)
      seg_last = 6'd23;
    else if (segment_pin_mask == 4'h7)
      seg_last = 6'd24;
    else if (segment_pin_mask == 4'hF)
      seg_last = 6'd39;
    else if (segment_pin_mask < 4'h6)
      seg_last = 6'd12 + {1'b0, segment_pin_mask, 1'b0};
    else
      seg_last = 6'd10 + {1'b0, segment_pin_mask, 1'b0};
  end

  // unmasked or disabled segments are port
  genvar gi;
  for (gi = 0; gi < SEG_COUNT; gi++)
  begin : g_seg
    assign seg_lcd_o[gi] = (state == SLC_RUN) && panel_driver_on
                           && (6'(gi) <= seg_last);
  end

  for (gi = 0; gi < 4; gi++)
  begin : g_com
    assign com_lcd_o[gi] = (state == SLC_RUN) && panel_driver_on
                           && (2'(gi) <= duty_sel);
  end

  assign low_power_active_o = lp_active;
  assign blank_gnd_o        = (state == SLC_RUN) && panel_driver_on && blank_active;
  assign half_bias_o        = half_bias_sel && (duty_sel != SLC_DUTY_STATIC);
  assign duty_o             = duty_sel;
  assign frame_start_o      = frame_begin;
  assign panel_tick_o       = prescaled_panel_clock;
  assign frame_phase_o      = phase;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  irq_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    frame_irq_o == (frame_start_flag && frame_irq_enable && global_irq_en_i))
    else $error("frame interrupt gating wrong");

  flag_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    latch_now |=> frame_start_flag)
    else $error("flag not set at frame start");

  flag_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (irq_ack_i && !latch_now) |=> !frame_start_flag)
    else $error("flag not cleared by vector");

  flag_w0_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (frame_start_flag && wr_a && !wdata_i[SLC_A_FLAG] && !irq_ack_i) |=> frame_start_flag)
    else $error("writing zero cleared flag");

  off_now_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !panel_driver_on |-> (seg_lcd_o == '0 && com_lcd_o == 4'h0 && !blank_gnd_o))
    else $error("pins still owned while disabled");
  lp_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state == SLC_RUN && !latch_now && panel_driver_on) |=> $stable(lp_active))
    else $error("waveform changed mid-frame");
  lp_pair_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (latch_now && low_power_waveform_sel) |=> (second_half && lp_active))
    else $error("flag set on consecutive low-power frames");
  frame_len_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (frame_begin && !frame_cut) |-> (phase == phase_last))
    else $error("frame length wrong");
  com_duty_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (panel_driver_on && state == SLC_RUN) |-> (com_lcd_o[0] && !com_lcd_o[3] ==
      (duty_sel != SLC_DUTY_QUARTER)))
    else $error("common ownership does not follow duty");
  reserved_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $past(rd_i) && $past(addr_i) == SLC_PANEL_CONTROL_A_OFS |-> rdata_o[5] == 1'b0
      && rdata_o[2:1] == 2'b00)
    else $error("reserved bits read nonzero");

  blank_gnd_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (blank_request && latch_now && panel_driver_on) |=> blank_gnd_o)
    else $error("blanking not applied at frame start");

endmodule : slc_top

`default_nettype wire

// *** rtl/slc_pkg.sv ***
package slc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SLC_PANEL_CONTROL_A_OFS = 8'hE4;
  localparam logic [7:0] SLC_PANEL_CONTROL_B_OFS = 8'hE5;
  localparam logic [7:0] SLC_FRAME_RATE_OFS      = 8'hE6;

  localparam logic [7:0] SLC_CTRL_A_RESET = 8'h00;
  localparam logic [7:0] SLC_CTRL_B_RESET = 8'h00;
  localparam logic [7:0] SLC_FRR_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SLC_A_DRIVER_ON  = 7;
  localparam int SLC_A_LP_WAVE    = 6;
  localparam int SLC_A_FLAG       = 4;
  localparam int SLC_A_IRQ_EN     = 3;
  localparam int SLC_A_BLANK      = 0;

  localparam int SLC_B_ASYNC_SEL  = 7;
  localparam int SLC_B_HALF_BIAS  = 6;
  localparam int SLC_B_DUTY_LO    = 4;
  localparam int SLC_B_MASK_LO    = 0;

  localparam int SLC_F_TAP_LO     = 4;
  localparam int SLC_F_DIV_LO     = 0;

  // ----------------------------------------------------------------
  // Duty codes and frame lengths
  // ----------------------------------------------------------------
  localparam logic [1:0] SLC_DUTY_STATIC  = 2'h0;
  localparam logic [1:0] SLC_DUTY_HALF    = 2'h1;
  localparam logic [1:0] SLC_DUTY_THIRD   = 2'h2;
  localparam logic [1:0] SLC_DUTY_QUARTER = 2'h3;

  localparam logic [2:0] SLC_K_THIRD_LAST = 3'h5;
  localparam logic [2:0] SLC_K_OTHER_LAST = 3'h7;

  // Prescaler width and low-bit counts per tap (16 .. 4096)
  localparam int SLC_PRE_W = 12;
  localparam logic [3:0] SLC_TAP_BITS [8] = '{4'h4, 4'h6, 4'h7, 4'h8,
                                              4'h9, 4'hA, 4'hB, 4'hC};

  typedef enum logic {SLC_IDLE, SLC_RUN} slc_state_t;

endpackage : slc_pkg

// *** rtl/slc_clk_div.sv ***
`timescale 1ns/1ps
`default_nettype none

module slc_clk_div
  import slc_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic       async_sel_i,
  input  wire logic       ext_clk_en_i,
  input  wire logic       tosc_clk_i,
  input  wire logic       ext_clk_i,
  input  wire logic [2:0] tap_sel_i,
  input  wire logic [2:0] div_sel_i,
  output logic            tick_o
);

  logic                 src_prev;
  logic                 src_now;
  logic                 panel_en;
  logic [SLC_PRE_W-1:0] pre_cnt;
  logic [SLC_PRE_W-1:0] tap_mask;
  logic                 tap_hit;
  logic [2:0]           div_cnt;

  // ----------------------------------------------------------------
  // Panel clock source
  // ----------------------------------------------------------------
  assign src_now = ext_clk_en_i ? ext_clk_i : tosc_clk_i;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      src_prev <= 1'b0;
    else
      src_prev <= src_now;
  end

  // System clock steps every cycle; slow clock on its rising edges
  assign panel_en = async_sel_i ? (src_now & ~src_prev) : 1'b1;

  // ----------------------------------------------------------------
  // Prescaler tap and divider
  // ----------------------------------------------------------------
  assign tap_mask = SLC_PRE_W'((13'h1 << SLC_TAP_BITS[tap_sel_i]) - 13'h1);
  assign tap_hit  = panel_en && ((pre_cnt & tap_mask) == tap_mask);

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pre_cnt <= '0;
    else if (!run_i)
      pre_cnt <= '0;
    else if (panel_en)
      pre_cnt <= pre_cnt + SLC_PRE_W'(1);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      div_cnt <= 3'h0;
    else if (!run_i)
      div_cnt <= 3'h0;
    else if (tap_hit)
      div_cnt <= (div_cnt >= div_sel_i) ? 3'h0 : div_cnt + 3'h1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tick_o <= 1'b0;
    else
      tick_o <= run_i && tap_hit && (div_cnt >= div_sel_i);
  end

endmodule : slc_clk_div

`default_nettype wire

// *** tb/slc_glass_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module slc_glass_model
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  com_lcd_i,
  input  wire logic [39:0] seg_lcd_i,
  input  wire logic        blank_gnd_i,
  output logic             energized_o
);
  // --------------------------------------------
  // Passive glass
  // --------------------------------------------
  // Grounded glass dark
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      energized_o <= 1'b0;
    else
      energized_o <= (|com_lcd_i) && (|seg_lcd_i) && !blank_gnd_i;
  end
endmodule : slc_glass_model

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import slc_pkg::*;
;
  localparam logic [7:0] RA = SLC_PANEL_CONTROL_A_OFS;
  localparam logic [7:0] RB = SLC_PANEL_CONTROL_B_OFS;
  localparam logic [7:0] RF = SLC_FRAME_RATE_OFS;
  localparam int SEGS [16] = '{13, 15, 17, 19, 21, 23, 24, 25,
                               27, 29, 31, 33, 35, 37, 39, 40};
  localparam logic [7:0] FRS [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h07, 8'h00};
  localparam logic [7:0] CRB [6] = '{8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h20};
  localparam int PER [6] = '{128, 512, 1024, 2048, 1024, 96};

  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [7:0]  wdata   = 8'h00;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        ext_en  = 1'b0;
  logic        gie     = 1'b0;
  logic        ack     = 1'b0;
  logic [2:0]  div     = 3'h0;
  logic [7:0]  rdata;
  logic        irq, fs, tick, lp, blank, hb, lit;
  logic [2:0]  phase;
  logic [1:0]  duty;
  logic [3:0]  com;
  logic [39:0] seg;
  int          failures    = 0;
  int          comparisons = 0;

  slc_top u_slc_top
  (
    .ref_clk_i          (ref_clk),
    .rst_n_i            (rst_n),
    .addr_i             (addr),
    .wdata_i            (wdata),
    .wr_i               (wr),
    .rd_i               (rd),
    .rdata_o            (rdata),
    .ext_clk_en_i       (ext_en),
    .tosc_clk_i         (div[2]),
    .ext_clk_i          (div[1]),
    .global_irq_en_i    (gie),
    .irq_ack_i          (ack),
    .frame_irq_o        (irq),
    .frame_start_o      (fs),
    .panel_tick_o       (tick),
    .frame_phase_o      (phase),
    .low_power_active_o (lp),
    .blank_gnd_o        (blank),
    .half_bias_o        (hb),
    .duty_o             (duty),
    .com_lcd_o          (com),
    .seg_lcd_o          (seg)
  );

  slc_glass_model u_slc_glass_model
  (
    .ref_clk_i   (ref_clk),
    .rst_n_i     (rst_n),
    .com_lcd_i   (com),
    .seg_lcd_i   (seg),
    .blank_gnd_i (blank),
    .energized_o (lit)
  );

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Slow sources: 80 ns and 40 ns, phase unrelated to frames
  always @(posedge ref_clk)
  begin
    div <= div + 3'h1;
  end

  // --------------------------------------------
  // Bus and check helpers
  // --------------------------------------------
  task automatic check(input string name, input logic [39:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input string name, input logic [7:0] a, exp);
    logic [7:0] d;
    rd_reg(a, d);
    check(name, 40'(d), 40'(exp));
  endtask : rd_chk

  task automatic wait_fs(output int n);
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (fs !== 1'b1 && n < 5000);
  endtask : wait_fs

  // Frames from an acknowledged flag to the next one
  task automatic flag_gap(output int f);
    int n;
    @(posedge ref_clk);
    ack <= 1'b1;
    @(posedge ref_clk);
    ack <= 1'b0;
    f = 0;
    do
    begin
      wait_fs(n);
      f++;
      @(negedge ref_clk);
    end
    while (irq !== 1'b1 && f < 4);
  endtask : flag_gap

  task automatic give_verdict();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // --------------------------------------------
  // Scenarios
  // --------------------------------------------
  task automatic t_regs();
    rd_chk("a_rst", RA, 8'h00);
    rd_chk("b_rst", RB, 8'h00);
    rd_chk("f_rst", RF, 8'h00);
    wr_reg(RA, 8'h6E);
    rd_chk("a_rsvd", RA, 8'h48);
    wr_reg(RF, 8'hFF);
    rd_chk("f_rsvd", RF, 8'h77);
    wr_reg(RB, 8'hFF);
    rd_chk("b_rw", RB, 8'hFF);
    wr_reg(8'hE7, 8'hFF);
    rd_chk("a_keep", RA, 8'h48);
    rd_chk("unmapped", 8'hE7, 8'h00);
    wr_reg(RA, 8'h00);
    wr_reg(RF, 8'h00);
  endtask : t_regs

  task automatic t_pins();
    logic [40:0] one;
    wr_reg(RB, 8'h3F);
    @(negedge ref_clk);
    check("com_off", 40'(com), 40'h0);
    check("seg_off", seg, 40'h0);
    wr_reg(RA, 8'h80);
    for (int i = 0; i < 16; i++)
    begin
      wr_reg(RB, {1'b0, i[2], i[1:0], i[3:0]});
      @(negedge ref_clk);
      one = (41'h1 << SEGS[i]) - 41'h1;
      check("seg", seg, one[39:0]);
      check("com", 40'(com), 40'((5'h2 << i[1:0]) - 5'h1));
      check("bias", 40'(hb), 40'(i[2] && i[1:0] != 2'h0));
      check("duty", 40'(duty), 40'(i[1:0]));
    end
  endtask : t_pins

  task automatic t_rate();
    int n;
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(RB, CRB[i]);
      wr_reg(RF, FRS[i]);
      wait_fs(n);
      wait_fs(n);
      check("frame_len", 40'(n), 40'(PER[i]));
      check("phase_end", 40'(phase), (i == 5) ? 40'h5 : 40'h7);
    end
  endtask : t_rate

  task automatic t_irq();
    int f;
    wr_reg(RA, 8'h88);
    gie <= 1'b1;
    flag_gap(f);
    check("gap", 40'(f), 40'h1);
    @(posedge ref_clk);
    gie <= 1'b0;
    @(negedge ref_clk);
    check("irq_gie", 40'(irq), 40'h0);
    @(posedge ref_clk);
    gie <= 1'b1;
    wr_reg(RA, 8'h80);
    @(negedge ref_clk);
    check("irq_ie", 40'(irq), 40'h0);
    wr_reg(RA, 8'h88);
    @(negedge ref_clk);
    check("flag_w0", 40'(irq), 40'h1);
    // Ack right after a frame start so no set meets the clear
    wait_fs(f);
    @(posedge ref_clk);
    ack <= 1'b1;
    @(posedge ref_clk);
    ack <= 1'b0;
    @(negedge ref_clk);
    check("flag_ack", 40'(irq), 40'h0);
    flag_gap(f);
    wr_reg(RA, 8'h98);
    rd_chk("flag_w1", RA, 8'h88);
  endtask : t_irq

  task automatic t_lp();
    int f;
    wr_reg(RA, 8'hC8);
    @(negedge ref_clk);
    check("lp_early", 40'(lp), 40'h0);
    flag_gap(f);
    flag_gap(f);
    check("lp_gap", 40'(f), 40'h2);
    check("lp_on", 40'(lp), 40'h1);
    wr_reg(RA, 8'h88);
    flag_gap(f);
    flag_gap(f);
    check("dflt_gap", 40'(f), 40'h1);
    check("lp_off", 40'(lp), 40'h0);
  endtask : t_lp

  task automatic t_blank();
    logic [7:0] d;
    int         n;
    flag_gap(n);
    check("glass_lit", 40'(lit), 40'h1);
    wr_reg(RA, 8'h91);
    @(negedge ref_clk);
    check("blank_wait", 40'(blank), 40'h0);
    d = 8'h00;
    n = 0;
    while (d[4] !== 1'b1 && n < 500)
    begin
      rd_reg(RA, d);
      n++;
    end
    check("blank_on", 40'(blank), 40'h1);
    check("glass_dark", 40'(lit), 40'h0);
    wr_reg(RA, 8'h00);
    @(negedge ref_clk);
    check("com_rel", 40'(com), 40'h0);
    check("seg_rel", seg, 40'h0);
    n = 0;
    repeat (200)
    begin
      @(negedge ref_clk);
      n += int'(tick === 1'b1 || fs === 1'b1);
    end
    check("idle", 40'(n), 40'h0);
    check("phase_idle", 40'(phase), 40'(SLC_K_OTHER_LAST));
  endtask : t_blank

  task automatic t_async();
    int n;
    wr_reg(RF, 8'h00);
    wr_reg(RB, 8'hB0);
    wr_reg(RA, 8'h80);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge ref_clk);
      ext_en <= k[0];
      wait_fs(n);
      wait_fs(n);
      check("async_len", 40'(n), (k == 1) ? 40'd512 : 40'd1024);
    end
  endtask : t_async

  initial
  begin
    repeat (50000) @(posedge ref_clk);
    failures++;
    give_verdict();
  end

  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_pins();
    t_rate();
    t_irq();
    t_lp();
    t_blank();
    t_async();
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
